// *** src/rdd_top.sv ***
// Reset domain distributor with supply switch and watchdog.
// Summary of operation
// RULE_01 - Power-on reset holds all five domains while supply is low.
// RULE_02 - Software reset clears every domain except the debug port.
// RULE_03 - Watchdog timeout resets all domains except the wakeup timer.
// RULE_04 - Watchdog starts disabled and needs a software enable to fire.
// RULE_05 - Watchdog counting pauses while the debugger halts the processor.
// RULE_06 - Low external reset pin resets all five domains.
// RULE_07 - Run from bus supply; switch to main above the dead battery threshold.
// RULE_08 - Sink path control stays operable on bus supply without I/O rail.
// RULE_09 - Brown-out of the main supply is flagged for firmware shutdown.
// RULE_10 - Each domain reset is an OR of sources, async set, sync release.
`timescale 1ns/100ps
module rdd_top
    import rdd_pkg::*;
#(
    parameter int WDOG_WIDTH = rdd_pkg::RDD_WDOG_WIDTH
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  supply_por,
    input  wire logic                  ext_reset_n,
    input  wire logic                  soft_reset_req,
    input  wire logic                  wdog_enable_set,
    input  wire logic                  wdog_kick,
    input  wire logic [WDOG_WIDTH-1:0] wdog_reload,
    input  wire logic                  wdog_reload_load,
    input  wire logic                  cpu_halted,
    input  wire logic                  main_above_dead_battery_threshold,
    input  wire logic                  main_below_min,
    input  wire logic                  io_supply_rail_ok,
    input  wire logic                  sink_path_request,
    output logic                       rst_core,
    output logic                       rst_debug_access_port,
    output logic                       rst_periph,
    output logic                       rst_wakeup,
    output logic                       rst_wdog,
    output logic                       wdog_enabled,
    output logic                       wdog_timeout,
    output logic                       power_from_main,
    output logic                       power_from_bus,
    output logic                       brown_out,
    output logic                       sink_path_control_pin,
    output logic                       sink_path_control_pin_oe_n
);
    import rdd_pkg::*;

    // Pin-side levels pass two flip-flops before use.
    logic [1:0] s_por;
    logic [1:0] s_pin_n;
    logic [1:0] s_main;
    logic [1:0] s_brown;
    logic [1:0] s_io;
    logic [1:0] next_s_por;
    logic [1:0] next_s_pin_n;
    logic [1:0] next_s_main;
    logic [1:0] next_s_brown;
    logic [1:0] next_s_io;

    always_comb begin
        next_s_por   = {s_por[0], supply_por};
        next_s_pin_n = {s_pin_n[0], ext_reset_n};
        next_s_main  = {s_main[0], main_above_dead_battery_threshold};
        next_s_brown = {s_brown[0], main_below_min};
        next_s_io    = {s_io[0], io_supply_rail_ok};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_por   <= 2'h3;
            s_pin_n <= 2'h3;
            s_main  <= 2'h0;
            s_brown <= 2'h0;
            s_io    <= 2'h0;
        end else begin
            s_por   <= next_s_por;
            s_pin_n <= next_s_pin_n;
            s_main  <= next_s_main;
            s_brown <= next_s_brown;
            s_io    <= next_s_io;
        end
    end

    // Watchdog state lives in the watchdog domain.
    logic                  wdog_en;
    logic [WDOG_WIDTH-1:0] wdog_cnt;
    logic [WDOG_WIDTH-1:0] wdog_rel;
    logic                  wdog_fire;
    logic                  next_wdog_en;
    logic [WDOG_WIDTH-1:0] next_wdog_cnt;
    logic [WDOG_WIDTH-1:0] next_wdog_rel;
    logic                  next_wdog_fire;

    always_comb begin
        next_wdog_en   = wdog_en;
        next_wdog_cnt  = wdog_cnt;
        next_wdog_rel  = wdog_rel;
        next_wdog_fire = 1'b0;
        if (wdog_reload_load) begin
            next_wdog_rel = wdog_reload;
        end
        // RULE_04 explicit enable
        if (wdog_enable_set && !wdog_en) begin
            next_wdog_en  = 1'b1;
            next_wdog_cnt = wdog_rel;
        end else if (wdog_en && wdog_kick) begin
            next_wdog_cnt = wdog_rel;
        // RULE_05 halt pause
        end else if (wdog_en && !cpu_halted) begin
            if (wdog_cnt == '0) begin
                // One pulse per expiry; the watchdog reset follows before it can repeat.
                next_wdog_fire = !wdog_fire;
            end else begin
                next_wdog_cnt = wdog_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || rst_wdog) begin
            wdog_en   <= RDD_WDOG_EN_RST;
            wdog_cnt  <= RDD_WDOG_RELOAD_RST[WDOG_WIDTH-1:0];
            wdog_rel  <= RDD_WDOG_RELOAD_RST[WDOG_WIDTH-1:0];
            wdog_fire <= 1'b0;
        end else begin
            wdog_en   <= next_wdog_en;
            wdog_cnt  <= next_wdog_cnt;
            wdog_rel  <= next_wdog_rel;
            wdog_fire <= next_wdog_fire;
        end
    end

    // Short pulses are stretched so every domain in the source's mask sees a full reset.
    logic [2:0] soft_str;
    logic [2:0] wdog_str;
    logic [2:0] next_soft_str;
    logic [2:0] next_wdog_str;

    always_comb begin
        next_soft_str = (soft_str != 3'h0) ? soft_str - 3'h1 : 3'h0;
        next_wdog_str = (wdog_str != 3'h0) ? wdog_str - 3'h1 : 3'h0;
        if (soft_reset_req) begin
            next_soft_str = 3'(RDD_STRETCH_CYCLES);
        end
        if (wdog_fire) begin
            next_wdog_str = 3'(RDD_STRETCH_CYCLES);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            soft_str <= 3'h0;
            wdog_str <= 3'h0;
        end else begin
            soft_str <= next_soft_str;
            wdog_str <= next_wdog_str;
        end
    end

    logic             src_por;
    logic             src_soft;
    logic             src_wdog;
    logic             src_pin;
    logic [RDD_DOMAINS-1:0] dom_req;
    logic [RDD_DOMAINS-1:0] dom_rst;

    // RULE_01 power-on source
    assign src_por  = s_por[1] | rst;
    // RULE_02 software source
    assign src_soft = soft_str != 3'h0;
    // RULE_03 watchdog source
    assign src_wdog = wdog_str != 3'h0;
    // RULE_06 pin source
    assign src_pin  = !s_pin_n[1];

    // RULE_10 domain OR
    assign dom_req = ({RDD_DOMAINS{src_por}}  & RDD_MASK_POR)
                   | ({RDD_DOMAINS{src_soft}} & RDD_MASK_SOFT)
                   | ({RDD_DOMAINS{src_wdog}} & RDD_MASK_WDOG)
                   | ({RDD_DOMAINS{src_pin}}  & RDD_MASK_PIN);

    genvar g;
    generate
        for (g = 0; g < RDD_DOMAINS; g++) begin : g_dom
            rdd_rst_release #(
                .STAGES (RDD_SYNC_STAGES)
            ) u_rel (
                .clk     (clk),
                .req     (dom_req[g]),
                .rst_out (dom_rst[g])
            );
        end
    endgenerate

    assign rst_core              = dom_rst[RDD_DOM_CORE];
    assign rst_debug_access_port = dom_rst[RDD_DOM_DEBUG];
    assign rst_periph            = dom_rst[RDD_DOM_PERIPH];
    assign rst_wakeup            = dom_rst[RDD_DOM_WAKEUP];
    assign rst_wdog              = dom_rst[RDD_DOM_WDOG];

    // Supply selection state.
    rdd_pwr_t pwr;
    rdd_pwr_t next_pwr;
    logic     sink_q;
    logic     next_sink_q;

    always_comb begin
        next_pwr = pwr;
        case (pwr)
            // RULE_07 bus to main
            RDD_PWR_BUS: begin
                if (s_main[1]) begin
                    next_pwr = RDD_PWR_MAIN;
                end
            end
            // RULE_09 brown-out guard
            RDD_PWR_MAIN: begin
                if (s_brown[1]) begin
                    next_pwr = RDD_PWR_LOW;
                end else if (!s_main[1]) begin
                    next_pwr = RDD_PWR_BUS;
                end
            end
            RDD_PWR_LOW: begin
                if (!s_main[1]) begin
                    next_pwr = RDD_PWR_BUS;
                end else if (!s_brown[1]) begin
                    next_pwr = RDD_PWR_MAIN;
                end
            end
            default: begin
                next_pwr = RDD_PWR_BUS;
            end
        endcase
        next_sink_q = sink_path_request;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwr    <= RDD_PWR_BUS;
            sink_q <= 1'b0;
        end else begin
            pwr    <= next_pwr;
            sink_q <= next_sink_q;
        end
    end

    assign wdog_enabled    = wdog_en;
    assign wdog_timeout    = wdog_fire;
    assign power_from_main = pwr == RDD_PWR_MAIN;
    assign power_from_bus  = pwr == RDD_PWR_BUS;
    assign brown_out       = pwr == RDD_PWR_LOW;
    assign sink_path_control_pin = sink_q;
    // RULE_08 sink without rail
    assign sink_path_control_pin_oe_n = !(s_io[1] || pwr == RDD_PWR_BUS);
endmodule // rdd_top

// *** src/rdd_pkg.sv ***
// Package with the constants of the reset domain distributor.
package rdd_pkg;
    localparam int RDD_SYNC_STAGES = 2;
    localparam int RDD_STRETCH_CYCLES = 4;
    localparam int RDD_WDOG_WIDTH = 32;
    localparam logic [31:0] RDD_WDOG_RELOAD_RST = 32'hFFFF_FFFF;
    localparam logic RDD_WDOG_EN_RST = 1'b0;
    localparam int RDD_DOMAINS = 5;
    localparam int RDD_DOM_CORE = 0;
    localparam int RDD_DOM_DEBUG = 1;
    localparam int RDD_DOM_PERIPH = 2;
    localparam int RDD_DOM_WAKEUP = 3;
    localparam int RDD_DOM_WDOG = 4;
    localparam logic [4:0] RDD_MASK_POR = 5'h1F;
    localparam logic [4:0] RDD_MASK_SOFT = 5'h1D;
    localparam logic [4:0] RDD_MASK_WDOG = 5'h17;
    localparam logic [4:0] RDD_MASK_PIN = 5'h1F;

    typedef enum logic [1:0] {
        RDD_PWR_BUS  = 2'b00,
        RDD_PWR_MAIN = 2'b01,
        RDD_PWR_LOW  = 2'b11
    } rdd_pwr_t;
endpackage

// *** src/rdd_rst_release.sv ***
// Reset output cell that asserts at once and releases on the clock.
`timescale 1ns/100ps
module rdd_rst_release #(
    parameter int STAGES = 2
) (
    input  wire logic clk,
    input  wire logic req,
    output logic      rst_out
);
    logic [STAGES-1:0] chain;

    // RULE_10 async assert
    always_ff @(posedge clk or posedge req) begin
        if (req) begin
            chain <= '1;
        end else begin
            chain <= {chain[STAGES-2:0], 1'b0};
        end
    end

    assign rst_out = chain[STAGES-1];
endmodule // rdd_rst_release

// *** testbench/rdd_top_properties.sv ***
// Checker of the reset domain distributor top ports.
`timescale 1ns/100ps
module rdd_top_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_por,
    input wire logic ext_reset_n,
    input wire logic soft_reset_req,
    input wire logic wdog_enable_set,
    input wire logic cpu_halted,
    input wire logic main_above_dead_battery_threshold,
    input wire logic main_below_min,
    input wire logic sink_path_request,
    input wire logic rst_core,
    input wire logic rst_debug_access_port,
    input wire logic rst_periph,
    input wire logic rst_wakeup,
    input wire logic rst_wdog,
    input wire logic wdog_enabled,
    input wire logic wdog_timeout,
    input wire logic power_from_main,
    input wire logic power_from_bus,
    input wire logic brown_out,
    input wire logic sink_path_control_pin,
    input wire logic sink_path_control_pin_oe_n
);
    wire logic [4:0] doms = {rst_wdog, rst_wakeup, rst_periph, rst_debug_access_port, rst_core};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_por; supply_por [*3] |-> ##[0:2] (doms == 5'h1F); endproperty
    a_por: assert property (p_por) else $error("por missed a domain");
    property p_soft; soft_reset_req |-> ##[1:2] ((doms & 5'h1D) == 5'h1D); endproperty
    a_soft: assert property (p_soft) else $error("soft reset missed a domain");
    property p_wdog; wdog_timeout |-> ##[1:2] ((doms & 5'h17) == 5'h17); endproperty
    a_wdog: assert property (p_wdog) else $error("timeout missed a domain");
    property p_off; !wdog_enabled && !wdog_enable_set |=> !wdog_timeout; endproperty
    a_off: assert property (p_off) else $error("timeout while disabled");
    property p_halt; cpu_halted [*3] |-> !wdog_timeout; endproperty
    a_halt: assert property (p_halt) else $error("timeout while halted");
    property p_pin; !ext_reset_n [*3] |-> ##[0:2] (doms == 5'h1F); endproperty
    a_pin: assert property (p_pin) else $error("pin reset missed a domain");
    property p_main;
        (main_above_dead_battery_threshold && !main_below_min) [*4] |-> power_from_main;
    endproperty
    a_main: assert property (p_main) else $error("no switch to main");
    property p_one; $onehot({power_from_main, power_from_bus, brown_out}); endproperty
    a_one: assert property (p_one) else $error("power state not one-hot");
    property p_sink; sink_path_request |=> sink_path_control_pin; endproperty
    a_sink: assert property (p_sink) else $error("sink pin did not follow");
    property p_bus_drive; power_from_bus |-> !sink_path_control_pin_oe_n; endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("sink pin undriven on bus");
    property p_brown;
        (power_from_main && main_below_min) ##1 main_below_min [*3] |-> brown_out;
    endproperty
    a_brown: assert property (p_brown) else $error("brown-out not flagged");
endmodule // rdd_top_properties
bind rdd_top rdd_top_properties props (.clk, .rst, .supply_por, .ext_reset_n,
    .soft_reset_req, .wdog_enable_set, .cpu_halted, .main_above_dead_battery_threshold,
    .main_below_min, .sink_path_request, .rst_core, .rst_debug_access_port, .rst_periph,
    .rst_wakeup, .rst_wdog, .wdog_enabled, .wdog_timeout, .power_from_main,
    .power_from_bus, .brown_out, .sink_path_control_pin, .sink_path_control_pin_oe_n);

// *** testbench/rdd_supply_model.sv ***
// Model of the supply monitors, reset pin and processor halt line.
`timescale 1ns/100ps
module rdd_supply_model (
    input  wire logic       clk,
    input  wire logic [5:0] req,
    output logic            supply_por,
    output logic            ext_reset_n,
    output logic            cpu_halted,
    output logic            main_above_dead_battery_threshold,
    output logic            main_below_min,
    output logic            io_supply_rail_ok
);
    always_ff @(posedge clk) begin
        {supply_por, ext_reset_n, cpu_halted, main_above_dead_battery_threshold,
            main_below_min, io_supply_rail_ok} <= req;
    end
endmodule // rdd_supply_model

// *** testbench/rdd_top_bench.sv ***
// Self-checking bench of the reset domain distributor.
`timescale 1ns/100ps
module rdd_top_bench;
    import rdd_pkg::*;
    logic        clk               = 1'b0;
    logic        rst               = 1'b1;
    logic [5:0]  req               = 6'h10;
    logic        soft_reset_req    = 1'b0;
    logic        wdog_enable_set   = 1'b0;
    logic        wdog_kick         = 1'b0;
    logic [31:0] wdog_reload       = 32'h0000_0008;
    logic        wdog_reload_load  = 1'b0;
    logic        sink_path_request = 1'b0;
    logic        supply_por, ext_reset_n, cpu_halted, main_above_dead_battery_threshold;
    logic        main_below_min, io_supply_rail_ok, rst_core, rst_debug_access_port;
    logic        rst_periph, rst_wakeup, rst_wdog, wdog_enabled, wdog_timeout;
    logic        power_from_main, power_from_bus, brown_out, sink_path_control_pin;
    logic        sink_path_control_pin_oe_n;
    int          miscompares       = 0;
    int          n_checks          = 0;
    wire  [4:0]  doms = {rst_wdog, rst_wakeup, rst_periph, rst_debug_access_port, rst_core};
    rdd_supply_model model (.clk, .req, .supply_por, .ext_reset_n, .cpu_halted,
        .main_above_dead_battery_threshold, .main_below_min, .io_supply_rail_ok);
    rdd_top DUT (.clk, .rst, .supply_por, .ext_reset_n, .soft_reset_req, .wdog_enable_set,
        .wdog_kick, .wdog_reload, .wdog_reload_load, .cpu_halted,
        .main_above_dead_battery_threshold, .main_below_min, .io_supply_rail_ok,
        .sink_path_request, .rst_core, .rst_debug_access_port, .rst_periph, .rst_wakeup,
        .rst_wdog, .wdog_enabled, .wdog_timeout, .power_from_main, .power_from_bus,
        .brown_out, .sink_path_control_pin, .sink_path_control_pin_oe_n);
    always #2 clk = ~clk;
    task chk(input string what, input logic [4:0] seen, input logic [4:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task wait_clear;
        for (int i = 0; i < 40 && doms !== 5'h00; i++) begin
            @(posedge clk);
            #1;
        end
        chk("domains released", doms, 5'h00);
        if (doms !== 5'h00) results();
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task t_power;
        @(posedge clk);
        sink_path_request <= 1'b1;
        step(2);
        chk("sink pin on bus", {3'h0, sink_path_control_pin, sink_path_control_pin_oe_n}, 5'h02);
        chk("bus power", {3'h0, power_from_bus, power_from_main}, 5'h02);
        @(posedge clk);
        req[2] <= 1'b1;
        step(5);
        chk("main power", {3'h0, power_from_bus, power_from_main}, 5'h01);
        chk("sink pin on main without rail", {3'h0, sink_path_control_pin, sink_path_control_pin_oe_n}, 5'h03);
        @(posedge clk);
        req[1] <= 1'b1;
        step(5);
        chk("brown out", {4'h0, brown_out}, 5'h01);
        @(posedge clk);
        req[1] <= 1'b0;
        req[0] <= 1'b1;
        step(5);
        chk("brown out cleared", {4'h0, brown_out}, 5'h00);
        chk("sink pin with rail", {3'h0, sink_path_control_pin, sink_path_control_pin_oe_n}, 5'h02);
        $display("power test done");
    endtask
    task t_src(input int b, input string what);
        @(posedge clk);
        req[b] <= ~req[b];
        step(5);
        chk(what, doms, 5'h1F);
        @(posedge clk);
        req[b] <= ~req[b];
        wait_clear();
        $display("%s test done", what);
    endtask
    task t_soft;
        @(posedge clk);
        soft_reset_req <= 1'b1;
        @(posedge clk);
        soft_reset_req <= 1'b0;
        step(2);
        chk("soft domains", doms, RDD_MASK_SOFT);
        wait_clear();
        $display("soft test done");
    endtask
    task t_wdog;
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        wdog_kick <= 1'b1;
        wdog_reload_load <= 1'b1;
        @(posedge clk);
        wdog_kick <= 1'b0;
        wdog_reload_load <= 1'b0;
        req[3] <= 1'b1;
        wdog_enable_set <= 1'b1;
        @(posedge clk);
        wdog_enable_set <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            step(1);
            seen = seen | wdog_timeout;
        end
        chk("enabled", {4'h0, wdog_enabled}, 5'h01);
        chk("timeout while halted", {4'h0, seen}, 5'h00);
        @(posedge clk);
        req[3] <= 1'b0;
        step(5);
        @(posedge clk);
        wdog_kick <= 1'b1;
        @(posedge clk);
        wdog_kick <= 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 4; i++) begin
            step(1);
            seen = seen | wdog_timeout;
        end
        chk("timeout after kick", {4'h0, seen}, 5'h00);
        for (int i = 0; i < 30 && wdog_timeout !== 1'b1; i++) step(1);
        chk("timeout", {4'h0, wdog_timeout}, 5'h01);
        if (wdog_timeout !== 1'b1) results();
        step(1);
        chk("timeout pulse length", {4'h0, wdog_timeout}, 5'h00);
        step(1);
        chk("wdog domains", doms, RDD_MASK_WDOG);
        wait_clear();
        chk("disabled again", {4'h0, wdog_enabled}, 5'h00);
        $display("watchdog test done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wait_clear();
        chk("enabled after reset", {4'h0, wdog_enabled}, 5'h00);
        t_power();
        t_src(5, "por");
        t_src(4, "pin");
        t_soft();
        t_wdog();
        results();
    end
endmodule // rdd_top_bench
